// >>> rtl/sfab_defs.vh
// Purpose: Constants for the status-flag ALU and branch slice
// Assumes: 8-bit datapath, 16-bit program counter
// Notes: Status bit positions, operation codes, cycle counts
`ifndef SFAB_DEFS_VH
`define SFAB_DEFS_VH

`define SFAB_FLAG_C 0
`define SFAB_FLAG_Z 1
`define SFAB_FLAG_N 2
`define SFAB_FLAG_V 3
`define SFAB_FLAG_S 4
`define SFAB_FLAG_H 5
`define SFAB_FLAG_T 6
`define SFAB_FLAG_I 7
`define SFAB_STATUS_RESET 8'h00
`define SFAB_ALL_ONES 8'hff

// Operation codes presented by the decoder
`define SFAB_OP_NOP   5'h00
`define SFAB_OP_ADD   5'h01
`define SFAB_OP_ADC   5'h02
`define SFAB_OP_SUB   5'h03
`define SFAB_OP_SBC   5'h04
`define SFAB_OP_AND   5'h05
`define SFAB_OP_OR    5'h06
`define SFAB_OP_XOR   5'h07
`define SFAB_OP_CLRB  5'h08
`define SFAB_OP_INC   5'h09
`define SFAB_OP_DEC   5'h0a
`define SFAB_OP_TST   5'h0b
`define SFAB_OP_CP    5'h0c
`define SFAB_OP_CPC   5'h0d
`define SFAB_OP_WADD  5'h0e
`define SFAB_OP_WSUB  5'h0f
`define SFAB_OP_INDIRECT_JUMP  5'h10
`define SFAB_OP_RELATIVE_CALL 5'h11
`define SFAB_OP_INDIRECT_CALL 5'h12
`define SFAB_OP_CALL  5'h13
`define SFAB_OP_COMPARE_SKIP_EQUAL  5'h14
`define SFAB_OP_SKRC  5'h15
`define SFAB_OP_SKRS  5'h16
`define SFAB_OP_SKIC  5'h17
`define SFAB_OP_SKIS  5'h18
`define SFAB_OP_BRS   5'h19
`define SFAB_OP_BRC   5'h1a
`define SFAB_OP_INTERRUPT_RETURN  5'h1b
`define SFAB_OP_IRQ   5'h1c
`define SFAB_OP_WRSR  5'h1d

`define SFAB_CYC_JMP  2'd2
`define SFAB_CYC_CALL 2'd3

`endif

// >>> rtl/sfab_alu8.v
// Purpose: Eight-bit arithmetic and logic unit with flag results
// Assumes: Carry in is the current status carry
// Notes: Subtract carry is a borrow, as the flags expect
`timescale 1ns/10ps
`include "sfab_defs.vh"
module sfab_alu8 (
  input  wire [4:0] op,
  input  wire [7:0] a,
  input  wire [7:0] b,
  input  wire       cin,
  output reg  [7:0] res,
  output reg        c_out,
  output reg        v_out,
  output reg        h_out
);
  reg [8:0] sum;
  reg [4:0] lo;
  always @* begin
    sum   = 9'h000;
    lo    = 5'h00;
    res   = 8'h00;
    c_out = 1'b0;
    v_out = 1'b0;
    h_out = 1'b0;
    case (op)
      `SFAB_OP_ADD, `SFAB_OP_ADC: begin
        sum   = {1'b0, a} + {1'b0, b} + {8'h00, (op == `SFAB_OP_ADC) & cin};
        lo    = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, (op == `SFAB_OP_ADC) & cin};
        res   = sum[7:0];
        c_out = sum[8];
        h_out = lo[4];
        v_out = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
      end
      `SFAB_OP_SUB, `SFAB_OP_SBC, `SFAB_OP_CP, `SFAB_OP_CPC: begin
        sum   = {1'b0, a} - {1'b0, b}
              - {8'h00, ((op == `SFAB_OP_SBC) | (op == `SFAB_OP_CPC)) & cin};
        lo    = {1'b0, a[3:0]} - {1'b0, b[3:0]}
              - {4'h0, ((op == `SFAB_OP_SBC) | (op == `SFAB_OP_CPC)) & cin};
        res   = sum[7:0];
        c_out = sum[8];
        h_out = lo[4];
        v_out = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
      end
      `SFAB_OP_AND, `SFAB_OP_TST: res = a & ((op == `SFAB_OP_TST) ? a : b);
      `SFAB_OP_OR:   res = a | b;
      `SFAB_OP_XOR:  res = a ^ b;
      `SFAB_OP_CLRB: res = a & (`SFAB_ALL_ONES - b);
      `SFAB_OP_INC: begin
        res   = a + 8'h01;
        v_out = (a == 8'h7f);
      end
      `SFAB_OP_DEC: begin
        res   = a - 8'h01;
        v_out = (a == 8'h80);
      end
      default: res = 8'h00;
    endcase
  end
endmodule // sfab_alu8

// >>> rtl/sfab_cond.v
// Purpose: Branch and skip condition evaluation
// Assumes: Status byte is the current registered flags
// Notes: Signed and unsigned branch forms map onto flag index and sense
`timescale 1ns/10ps
`include "sfab_defs.vh"
module sfab_cond (
  input  wire [4:0] op,
  input  wire [7:0] status,
  input  wire [2:0] sel,
  input  wire       signed_sel,
  input  wire [7:0] rd,
  input  wire [7:0] rr,
  input  wire [7:0] io_val,
  output reg        hit
);
  reg flag;
  always @* begin
    flag = signed_sel ? (status[`SFAB_FLAG_N] ^ status[`SFAB_FLAG_V]) : status[sel];
    case (op)
      `SFAB_OP_COMPARE_SKIP_EQUAL: hit = (rd == rr);
      `SFAB_OP_SKRC: hit = ~rr[sel];
      `SFAB_OP_SKRS: hit = rr[sel];
      `SFAB_OP_SKIC: hit = ~io_val[sel];
      `SFAB_OP_SKIS: hit = io_val[sel];
      `SFAB_OP_BRS:  hit = flag;
      `SFAB_OP_BRC:  hit = ~flag;
      default:       hit = 1'b0;
    endcase
  end
endmodule // sfab_cond

// >>> rtl/sfab_core.v
// Purpose: Status flags, ALU result and program-counter update slice
// Assumes: Decoder presents one instruction per issue pulse, holds operands
// Notes: busy stays high while a multi-cycle instruction completes
`timescale 1ns/10ps
`include "sfab_defs.vh"
// Notes on behaviour
// - Sign flag always equals negative xor overflow.
// - Bit 3 holds overflow of latest flag-affecting arithmetic.
// - Bit 2 set on negative result, else cleared.
// - Bit 1 set on zero result, else cleared; SBC and CPC also need Z already set.
// - Bit 0 takes carry of carry-affecting operations.
// - Add and add-with-carry write sum, update Z C N V H.
// - Word add and subtract immediate work on 16-bit pair, update Z C N V S.
// - Subtract forms write difference, update Z C N V H.
// - AND, OR, XOR update Z N V only; carry and half-carry kept.
// - Clear-bits ANDs with ones minus constant; set-bits ORs; Z N V only.
// - Increment, decrement, test take one cycle, update Z N V.
// - Indirect jump loads PC from Z, two cycles, flags kept.
// - Calls take three cycles, loading relative, Z or absolute target.
// - Compare-skip-equal skips next instruction on match, 1/2/3 cycles.
// - Compares set Z N V C H without write-back.
// - Register-bit skip advances PC by 2 or 3 on bit state.
// - I/O-bit skip tests port bit, skips, flags kept.
// - Flag branches test indexed bit, taken gives PC plus offset plus one.
// - Signed branches decide on negative xor overflow.
// - Unsigned branches taken on carry clear or set.
// - Half-carry and bit-copy branches taken on set or clear per variant.
// - Overflow, equal, minus and related branches test V, Z, N.
// - Taking an interrupt clears global enable; interrupt return sets it.
// - Bit 5 holds low-nibble carry of half-carry operations.
module sfab_core #(
  parameter PC_W = 16
) (
  input  wire            ref_clk,
  input  wire            rst,
  input  wire            issue,
  input  wire [4:0]      op,
  input  wire [7:0]      rd_val,
  input  wire [7:0]      rr_val,
  input  wire [7:0]      imm,
  input  wire [7:0]      rd_hi_val,
  input  wire [2:0]      bit_sel,
  input  wire            signed_sel,
  input  wire [7:0]      io_val,
  input  wire [PC_W-1:0] pc_in,
  input  wire [PC_W-1:0] offset,
  input  wire [PC_W-1:0] z_ptr,
  input  wire [PC_W-1:0] abs_target,
  input  wire            use_imm,
  input  wire            next_two_word,
  input  wire [7:0]      sr_wdata,
  output reg  [7:0]      status_flags,
  output reg  [7:0]      result_r,
  output reg  [7:0]      result_hi_r,
  output reg             result_we_r,
  output reg  [PC_W-1:0] pc_next_r,
  output reg             pc_load_r,
  output reg             busy_r
);
  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;

  wire [7:0] opb = use_imm ? imm : rr_val;
  wire [7:0] alu_res;
  wire       alu_c;
  wire       alu_v;
  wire       alu_h;
  wire       cond_hit;

  reg  [1:0]      state_r;
  reg  [1:0]      wait_r;
  reg  [7:0]      status_nxt;
  reg  [7:0]      res_nxt;
  reg  [7:0]      res_hi_nxt;
  reg             we_nxt;
  reg  [PC_W-1:0] pc_nxt;
  reg             load_nxt;
  reg  [1:0]      cyc_nxt;
  reg  [15:0]     wsum;
  reg  [16:0]     wtmp;
  reg             n_t;
  reg             v_t;

  sfab_alu8 u_alu (
    .op    (op),
    .a     (rd_val),
    .b     (opb),
    .cin   (status_flags[`SFAB_FLAG_C]),
    .res   (alu_res),
    .c_out (alu_c),
    .v_out (alu_v),
    .h_out (alu_h)
  );

  sfab_cond u_cond (
    .op         (op),
    .status     (status_flags),
    .sel        (bit_sel),
    .signed_sel (signed_sel),
    .rd         (rd_val),
    .rr         (rr_val),
    .io_val     (io_val),
    .hit        (cond_hit)
  );

  always @* begin
    status_nxt = status_flags;
    res_nxt    = alu_res;
    res_hi_nxt = rd_hi_val;
    we_nxt     = 1'b0;
    pc_nxt     = pc_in + {{(PC_W-1){1'b0}}, 1'b1};
    load_nxt   = 1'b0;
    cyc_nxt    = 2'd0;
    wtmp       = 17'h00000;
    wsum       = 16'h0000;
    n_t        = alu_res[7];
    v_t        = alu_v;
    case (op)
      `SFAB_OP_ADD, `SFAB_OP_ADC, `SFAB_OP_SUB, `SFAB_OP_SBC,
      `SFAB_OP_CP, `SFAB_OP_CPC: begin
        we_nxt = (op != `SFAB_OP_CP) && (op != `SFAB_OP_CPC);
        status_nxt[`SFAB_FLAG_C] = alu_c;
        status_nxt[`SFAB_FLAG_H] = alu_h;
        status_nxt[`SFAB_FLAG_V] = alu_v;
        status_nxt[`SFAB_FLAG_N] = n_t;
        // Carry-chained forms keep zero only when the result is zero
        if ((op == `SFAB_OP_SBC) || (op == `SFAB_OP_CPC))
          status_nxt[`SFAB_FLAG_Z] = (alu_res == 8'h00) & status_flags[`SFAB_FLAG_Z];
        else
          status_nxt[`SFAB_FLAG_Z] = (alu_res == 8'h00);
      end
      `SFAB_OP_AND, `SFAB_OP_OR, `SFAB_OP_XOR, `SFAB_OP_CLRB,
      `SFAB_OP_INC, `SFAB_OP_DEC, `SFAB_OP_TST: begin
        we_nxt = (op != `SFAB_OP_TST);
        status_nxt[`SFAB_FLAG_V] = alu_v;
        status_nxt[`SFAB_FLAG_N] = n_t;
        status_nxt[`SFAB_FLAG_Z] = (alu_res == 8'h00);
      end
      `SFAB_OP_WADD, `SFAB_OP_WSUB: begin
        if (op == `SFAB_OP_WADD)
          wtmp = {1'b0, rd_hi_val, rd_val} + {9'h000, imm};
        else
          wtmp = {1'b0, rd_hi_val, rd_val} - {9'h000, imm};
        wsum = wtmp[15:0];
        res_nxt    = wsum[7:0];
        res_hi_nxt = wsum[15:8];
        we_nxt     = 1'b1;
        n_t = wsum[15];
        if (op == `SFAB_OP_WADD)
          v_t = ~rd_hi_val[7] & wsum[15];
        else
          v_t = rd_hi_val[7] & ~wsum[15];
        status_nxt[`SFAB_FLAG_C] = wtmp[16];
        status_nxt[`SFAB_FLAG_V] = v_t;
        status_nxt[`SFAB_FLAG_N] = n_t;
        status_nxt[`SFAB_FLAG_Z] = (wsum == 16'h0000);
      end
      `SFAB_OP_INDIRECT_JUMP: begin
        pc_nxt   = z_ptr;
        load_nxt = 1'b1;
        cyc_nxt  = `SFAB_CYC_JMP;
      end
      `SFAB_OP_RELATIVE_CALL, `SFAB_OP_INDIRECT_CALL, `SFAB_OP_CALL: begin
        load_nxt = 1'b1;
        cyc_nxt  = `SFAB_CYC_CALL;
        if (op == `SFAB_OP_RELATIVE_CALL)
          pc_nxt = pc_in + offset + {{(PC_W-1){1'b0}}, 1'b1};
        else if (op == `SFAB_OP_INDIRECT_CALL)
          pc_nxt = z_ptr;
        else
          pc_nxt = abs_target;
      end
      `SFAB_OP_COMPARE_SKIP_EQUAL, `SFAB_OP_SKRC, `SFAB_OP_SKRS, `SFAB_OP_SKIC, `SFAB_OP_SKIS: begin
        load_nxt = 1'b1;
        if (cond_hit) begin
          pc_nxt  = pc_in + (next_two_word ? {{(PC_W-2){1'b0}}, 2'd3}
                                           : {{(PC_W-2){1'b0}}, 2'd2});
          cyc_nxt = next_two_word ? 2'd3 : 2'd2;
        end
      end
      `SFAB_OP_BRS, `SFAB_OP_BRC: begin
        load_nxt = 1'b1;
        if (cond_hit) begin
          pc_nxt  = pc_in + offset + {{(PC_W-1){1'b0}}, 1'b1};
          cyc_nxt = 2'd2;
        end
      end
      `SFAB_OP_INTERRUPT_RETURN: status_nxt[`SFAB_FLAG_I] = 1'b1;
      `SFAB_OP_IRQ:  status_nxt[`SFAB_FLAG_I] = 1'b0;
      `SFAB_OP_WRSR: status_nxt = sr_wdata;
      default: status_nxt = status_flags;
    endcase
    status_nxt[`SFAB_FLAG_S] = status_nxt[`SFAB_FLAG_N] ^ status_nxt[`SFAB_FLAG_V];
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_flags <= `SFAB_STATUS_RESET;
      result_r     <= 8'h00;
      result_hi_r  <= 8'h00;
      result_we_r  <= 1'b0;
      pc_next_r    <= {PC_W{1'b0}};
      pc_load_r    <= 1'b0;
      busy_r       <= 1'b0;
      state_r      <= ST_IDLE;
      wait_r       <= 2'd0;
    end else begin
      result_we_r <= 1'b0;
      pc_load_r   <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (issue) begin
            status_flags <= status_nxt;
            result_r     <= res_nxt;
            result_hi_r  <= res_hi_nxt;
            result_we_r  <= we_nxt;
            pc_next_r    <= pc_nxt;
            pc_load_r    <= load_nxt;
            // Single-cycle ops finish at once; others hold busy
            if (cyc_nxt > 2'd1) begin
              busy_r  <= 1'b1;
              wait_r  <= cyc_nxt - 2'd2;
              state_r <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (wait_r == 2'd0) begin
            busy_r  <= 1'b0;
            state_r <= ST_IDLE;
          end else begin
            wait_r <= wait_r - 2'd1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule // sfab_core

// >>> test/sfab_core_asserts.sv
// Purpose: Port-level checks of the flag and branch slice
// Assumes: One clock, asynchronous active-high reset
// Notes: Bound to the core from the bench top
`timescale 1ns/10ps
`include "sfab_defs.vh"
module sfab_core_asserts #(
  parameter PC_W = 16
) (
  input wire            ref_clk,
  input wire            rst,
  input wire            issue,
  input wire [4:0]      op,
  input wire [7:0]      rd_val,
  input wire [7:0]      rr_val,
  input wire            signed_sel,
  input wire [PC_W-1:0] pc_in,
  input wire [PC_W-1:0] z_ptr,
  input wire [7:0]      status_flags,
  input wire [7:0]      result_r,
  input wire            result_we_r,
  input wire [PC_W-1:0] pc_next_r,
  input wire            pc_load_r,
  input wire            busy_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire acc = issue & ~busy_r;
  wire arith = (op == `SFAB_OP_ADD) | (op == `SFAB_OP_SUB);
  property p_sign;
    status_flags[4] == (status_flags[2] ^ status_flags[3]);
  endproperty
  a_sign: assert property (p_sign) else $error("sign flag wrong");
  property p_add;
    acc && op == `SFAB_OP_ADD |=> result_we_r &&
      {status_flags[0], result_r} == {1'b0, $past(rd_val)} + {1'b0, $past(rr_val)};
  endproperty
  a_add: assert property (p_add) else $error("add sum or carry wrong");
  property p_zero;
    acc && arith |=> status_flags[1] == (result_r == 8'h00) && status_flags[2] == result_r[7];
  endproperty
  a_zero: assert property (p_zero) else $error("zero or negative flag wrong");
  property p_ovf;
    acc && op == `SFAB_OP_ADD |=> status_flags[3] ==
      ($past(rd_val[7]) == $past(rr_val[7]) && result_r[7] != $past(rd_val[7]));
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag wrong");
  property p_logic;
    acc && (op == `SFAB_OP_AND || op == `SFAB_OP_OR || op == `SFAB_OP_XOR) |=>
      $stable(status_flags[0]) && $stable(status_flags[5]) && !status_flags[3];
  endproperty
  a_logic: assert property (p_logic) else $error("logic op flags wrong");
  property p_cp;
    acc && op == `SFAB_OP_CP |=> !result_we_r;
  endproperty
  a_cp: assert property (p_cp) else $error("compare wrote back");
  property p_indirect_jump;
    acc && op == `SFAB_OP_INDIRECT_JUMP |=> pc_load_r && busy_r && pc_next_r == $past(z_ptr) ##1 !busy_r;
  endproperty
  a_indirect_jump: assert property (p_indirect_jump) else $error("indirect jump wrong");
  property p_call;
    acc && op == `SFAB_OP_INDIRECT_CALL |=> pc_load_r && pc_next_r == $past(z_ptr) ##0
      busy_r [*2] ##1 !busy_r;
  endproperty
  a_call: assert property (p_call) else $error("indirect call wrong");
  property p_lt;
    acc && op == `SFAB_OP_BRS && signed_sel |=> pc_load_r &&
      (pc_next_r == $past(pc_in) + 1) == !($past(status_flags[2]) ^ $past(status_flags[3]));
  endproperty
  a_lt: assert property (p_lt) else $error("signed branch wrong");
endmodule // sfab_core_asserts

// >>> test/sfab_pc_model.sv
// Purpose: Program counter of the core beside the slice
// Assumes: Loads the slice's target, else steps once per accepted issue
// Notes: Reset address zero
`timescale 1ns/10ps
module sfab_pc_model (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        issue,
  input  wire        busy_r,
  input  wire        pc_load_r,
  input  wire [15:0] pc_next_r,
  output reg  [15:0] pc_in
);
  always @(posedge ref_clk or posedge rst) begin
    if (rst) pc_in <= 16'h0000;
    else if (pc_load_r) pc_in <= pc_next_r;
    else if (issue && !busy_r) pc_in <= pc_in + 16'h0001;
  end
endmodule // sfab_pc_model

// >>> test/status_flags_alu_branch_tb.sv
// Purpose: Self-checking bench for the flag and branch slice
// Assumes: Driver notes expectations, monitor compares after each issue
// Notes: Random operands from a fixed seed
`timescale 1ns/10ps
`include "sfab_defs.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module status_flags_alu_branch_tb;
  typedef struct packed {
    logic [7:0]  st;
    logic [7:0]  res;
    logic [7:0]  hi;
    logic [15:0] pc;
    logic [1:0]  kind;
  } sfab_note_t;
  reg        ref_clk = 0, rst = 1, issue = 0, signed_sel = 0, use_imm = 0, iss_d = 0, c;
  reg [4:0]  op = 0, o;
  reg [7:0]  rd_val = 0, rr_val = 0, imm = 0, st = 0, r, rh = 0, eh = 0;
  reg [16:0] wt;
  reg        wv;
  reg [2:0]  bit_sel = 0;
  reg [15:0] offset = 0, z_ptr = 0, p;
  wire [15:0] pc_in, pc_next_r;
  wire [7:0]  status_flags, result_r, result_hi_r;
  wire        result_we_r, pc_load_r, busy_r;
  reg [4:0] atbl [0:5] = '{`SFAB_OP_ADD, `SFAB_OP_SUB, `SFAB_OP_CP, `SFAB_OP_AND, `SFAB_OP_OR, `SFAB_OP_XOR};
  reg [4:0] ftbl [0:4] = '{`SFAB_OP_BRS, `SFAB_OP_BRC, `SFAB_OP_COMPARE_SKIP_EQUAL, `SFAB_OP_INDIRECT_JUMP, `SFAB_OP_INDIRECT_CALL};
  sfab_note_t q[$];
  sfab_note_t mt;
  int err_count = 0, checked = 0, cyc = 0, seed, i;
  always #10 ref_clk = ~ref_clk;
  sfab_core i_dut (.ref_clk, .rst, .issue, .op, .rd_val, .rr_val, .imm, .rd_hi_val(rh),
    .bit_sel, .signed_sel, .io_val(8'h00), .pc_in, .offset, .z_ptr, .abs_target(16'h0000),
    .use_imm, .next_two_word(1'b0), .sr_wdata(8'h00), .status_flags, .result_r,
    .result_hi_r, .result_we_r, .pc_next_r, .pc_load_r, .busy_r);
  sfab_pc_model i_pc (.ref_clk, .rst, .issue, .busy_r, .pc_load_r, .pc_next_r, .pc_in);
  function automatic [7:0] alu(input [4:0] f, input [7:0] a, input [7:0] b);
    reg [8:0] s;
    reg       v;
    begin
      case (f)
        `SFAB_OP_ADD: s = {1'b0, a} + {1'b0, b};
        `SFAB_OP_AND: s = {1'b0, a & b};
        `SFAB_OP_OR:  s = {1'b0, a | b};
        `SFAB_OP_XOR: s = {1'b0, a ^ b};
        default:      s = {1'b0, a} - {1'b0, b};
      endcase
      v = 1'b0;
      if (f == `SFAB_OP_ADD) begin
        st[0] = s[8];
        st[5] = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
        v = (a[7] == b[7]) && (s[7] != a[7]);
      end else if (!(f inside {`SFAB_OP_AND, `SFAB_OP_OR, `SFAB_OP_XOR})) begin
        st[0] = s[8];
        st[5] = a[3:0] < b[3:0];
        v = (a[7] != b[7]) && (s[7] != a[7]);
      end
      st[4:1] = {s[7] ^ v, v, s[7], s[7:0] == 8'h00};
      alu = s[7:0];
    end
  endfunction
  task run_op(input [1:0] k, input [15:0] pe);
    int n;
    begin
      issue = 1'b1;
      q.push_back('{st, r, eh, pe, k});
      @(negedge ref_clk);
      n = 0;
      if (busy_r) begin
        issue = 1'b0;
        while (busy_r && n < 8) begin
          n++;
          @(negedge ref_clk);
        end
      end
    end
  endtask
  task end_sim;
    begin
      $display("checked %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  always @(posedge ref_clk) iss_d <= issue && !busy_r && !rst;
  always @(negedge ref_clk) begin
    if (iss_d && q.size() > 0) begin
      mt = q.pop_front();
      `CHK(status_flags, mt.st)
      if (mt.kind == 2'd0) `CHK({result_we_r, result_r}, {1'b1, mt.res})
      if (mt.kind == 2'd1) `CHK(result_we_r, 1'b0)
      if (mt.kind == 2'd2) `CHK({pc_load_r, pc_next_r}, {1'b1, mt.pc})
      if (mt.kind == 2'd3) `CHK({result_we_r, result_hi_r, result_r}, {1'b1, mt.hi, mt.res})
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      end_sim;
    end
  end
  initial begin
    seed = $urandom(65434);
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    for (i = 0; i < 120; i++) begin
      rd_val = $urandom;
      rr_val = (i % 7 == 0) ? rd_val : 8'($urandom);
      imm = $urandom;
      if (i >= 24 && i[0]) begin
        o = ftbl[(i / 2) % 5];
        op = o;
        bit_sel = $urandom;
        signed_sel = (i % 3 == 0);
        offset = 16'h0001 + 16'($urandom_range(200, 0));
        z_ptr = $urandom_range(16'h7fff, 0);
        c = signed_sel ? st[2] ^ st[3] : st[bit_sel];
        case (o)
          `SFAB_OP_BRS:  p = c ? pc_in + offset + 16'h0001 : pc_in + 16'h0001;
          `SFAB_OP_BRC:  p = !c ? pc_in + offset + 16'h0001 : pc_in + 16'h0001;
          `SFAB_OP_COMPARE_SKIP_EQUAL: p = pc_in + ((rd_val == rr_val) ? 16'h0002 : 16'h0001);
          default:       p = z_ptr;
        endcase
        run_op(2'd2, p);
      end else begin
        o = atbl[i % 6];
        op = o;
        signed_sel = 1'b0;
        use_imm = (o != `SFAB_OP_ADD) && $urandom_range(1, 0);
        r = alu(o, rd_val, use_imm ? imm : rr_val);
        run_op({1'b0, o == `SFAB_OP_CP}, 16'h0000);
      end
    end
    // Word add and subtract on the register pair; half-carry is left alone
    for (i = 0; i < 16; i++) begin
      rd_val = $urandom;
      rh = $urandom;
      imm = $urandom;
      o = i[0] ? `SFAB_OP_WSUB : `SFAB_OP_WADD;
      op = o;
      if (i[0]) wt = {1'b0, rh, rd_val} - {9'h000, imm};
      else wt = {1'b0, rh, rd_val} + {9'h000, imm};
      wv = i[0] ? (rh[7] & ~wt[15]) : (~rh[7] & wt[15]);
      st[4:0] = {wt[15] ^ wv, wv, wt[15], wt[15:0] == 16'h0000, wt[16]};
      r = wt[7:0];
      eh = wt[15:8];
      run_op(2'd3, 16'h0000);
    end
    issue = 1'b0;
    repeat (4) @(negedge ref_clk);
    `CHK(q.size(), 0)
    end_sim;
  end
endmodule // status_flags_alu_branch_tb
bind sfab_core sfab_core_asserts #(.PC_W(PC_W)) i_chk (.ref_clk, .rst, .issue, .op, .rd_val,
  .rr_val, .signed_sel, .pc_in, .z_ptr, .status_flags, .result_r, .result_we_r, .pc_next_r,
  .pc_load_r, .busy_r);
